// ===== core/tdm_ctrl_pkg.sv
// shared constants, types and state layout for the tdm rate and timing control
package tdm_ctrl_pkg;

  // rate configuration codes
  typedef enum logic [2:0] {
    RATE_8M      = 3'h0,
    RATE_16M     = 3'h1,
    RATE_4M_8M   = 3'h2,
    RATE_16M_8M  = 3'h3,
    RATE_4M      = 3'h4,
    RATE_2M_4M   = 3'h5,
    RATE_2M      = 3'h6,
    RATE_INVALID = 3'h7
  } rate_code_t;

  // per-stream bit rate class
  typedef enum logic [1:0] {
    SR_2M  = 2'h0,
    SR_4M  = 2'h1,
    SR_8M  = 2'h2,
    SR_16M = 2'h3
  } stream_rate_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_MEAS = 2'h1
  } meas_state_t;

  localparam int NUM_STREAMS = 32;
  localparam int SPLIT_HI_LAST = 11;
  localparam int SPLIT_LO_LAST = 19;
  localparam int HALF_STREAMS = 16;
  localparam logic [3:0] IN_DELAY_MAX = 4'h9;
  localparam int OUT_ADV_STEP_NS = 15;
  localparam int OUT_ADV_MAX_NS = 45;
  localparam logic [1:0] MODE_VARIABLE = 2'h0;
  localparam logic [1:0] MODE_CONSTANT = 2'h2;
  localparam logic [1:0] MODE_PRBS = 2'h3;
  localparam int CM_PATTERN_LSB = 13;
  localparam int CM_ADDR_W = 13;
  localparam int OFFSET_W = 10;
  localparam logic [OFFSET_W-1:0] OFFSET_MAX = 10'h3FF;
  localparam int ERR_W = 16;
  localparam logic [ERR_W-1:0] ERR_MAX = 16'hFFFF;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  localparam logic [3:0] PRBS_ORDER = 4'hF;
  localparam logic [1:0] MEAS_FRAMES = 2'h2;

  // configuration arriving from the host side
  typedef struct packed {
    rate_code_t rateCode;
    logic startMeasure;
    logic [4:0] evalSelect;
    logic [NUM_STREAMS-1:0][3:0] inputDelay;
    logic [NUM_STREAMS-1:0][1:0] outputAdvance;
    logic blockProgMode;
    logic blockProgGoReq;
    logic [2:0] blockPattern;
    logic errorTestRun;
    logic errorCountClear;
    logic [4:0] monitorStream;
    logic [7:0] monitorChannel;
  } ctrl_cfg_t;

  // complete register state of the control top
  typedef struct packed {
    logic [3:0] mclkDiv;
    logic masterTick;
    logic fpPrev;
    logic fePrev;
    logic startPrev;
    logic lowSeen;
    meas_state_t measState;
    logic [1:0] measFrames;
    logic counting;
    logic [OFFSET_W-1:0] offsetCnt;
    logic [OFFSET_W-1:0] offsetResult;
    logic measDone;
    logic [2:0] bitDiv;
    logic [2:0] bitIdx;
    logic [7:0] chanIdx;
    logic [2:0] byteTick;
    logic [11:0] dmAddr;
    logic bank;
    logic goPrev;
    logic bpGo;
    logic [CM_ADDR_W-1:0] cmAddr;
    logic cmWe;
    logic [15:0] cmData;
    logic runPrev;
    logic clrPrev;
    logic [14:0] chkShift;
    logic [3:0] seedCnt;
    logic [ERR_W-1:0] errInt;
    logic [ERR_W-1:0] errCount;
    logic [NUM_STREAMS-1:0][3:0] inDelay;
    logic [NUM_STREAMS-1:0][1:0] outAdv;
    logic txPrbs;
    logic txUsePrbs;
    logic constDelay;
    logic readBank;
  } ctrl_state_t;

endpackage

// ===== core/stream_rate_map.sv
// bit rate class and presence of one stream for a given rate code
`timescale 1ns/1ns
module stream_rate_map
  import tdm_ctrl_pkg::*;
(
  // selection
  input wire tdm_ctrl_pkg::rate_code_t rateCode,
  input wire logic [4:0] streamIdx,
  // result
  output tdm_ctrl_pkg::stream_rate_t streamRate,
  output logic streamActive
);
  import tdm_ctrl_pkg::*;

  always_comb begin
    streamRate = SR_8M;
    streamActive = 1'b1;
    unique case (rateCode)
      RATE_8M: streamRate = SR_8M;
      RATE_16M: begin
        streamRate = SR_16M;
        streamActive = (int'(streamIdx) < HALF_STREAMS);
      end
      RATE_4M_8M: streamRate = (int'(streamIdx) < HALF_STREAMS) ? SR_4M : SR_8M;
      RATE_16M_8M: begin
        streamRate = (int'(streamIdx) <= SPLIT_HI_LAST) ? SR_16M : SR_8M;
        streamActive = (int'(streamIdx) <= SPLIT_LO_LAST);
      end
      RATE_4M: streamRate = SR_4M;
      RATE_2M_4M: streamRate = (int'(streamIdx) < HALF_STREAMS) ? SR_2M : SR_4M;
      RATE_2M: streamRate = SR_2M;
      default: begin
        streamRate = SR_2M;
        streamActive = 1'b0;
      end
    endcase
  end

endmodule

// ===== core/prbs_lfsr.sv
// 2^15-1 pseudo-random pattern generator stepped by an enable
`timescale 1ns/1ns
module prbs_lfsr
  import tdm_ctrl_pkg::*;
#(
  parameter int WIDTH = 15
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic stepEn,
  // pattern
  output logic patternBit
);
  import tdm_ctrl_pkg::*;

  logic [WIDTH-1:0] shift_q;
  logic [WIDTH-1:0] shift_d;

  always_comb begin
    shift_d = shift_q;
    if (stepEn) begin
      shift_d = {shift_q[WIDTH-2:0], shift_q[WIDTH-1] ^ shift_q[WIDTH-2]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_q <= PRBS_SEED[WIDTH-1:0];
    end else begin
      shift_q <= shift_d;
    end
  end

  assign patternBit = shift_q[WIDTH-1];

endmodule

// ===== core/tdm_rate_timing_ctrl.sv
// rate selection, frame offset measurement, delays, block fill and bit error test
// Functional notes
// - code 011: streams 0-11 at 16M, 12-19 at 8M, twenty streams.
// - code 100: all 32 streams at 4M, 64 channels each.
// - code 101: streams 0-15 at 2M, 16-31 at 4M.
// - code 110: all 32 streams at 2M, 32 channels each.
// - five-bit select routes one of 32 evaluation inputs to measurement.
// - start bit must sit low a frame; measurement starts on its rise.
// - two frames after start, done flag rises with 10-bit offset result.
// - offset is frame pulse fall to evaluation fall, in master ticks.
// - input delay applies only to 4, 8, 16M streams, never 2M.
// - eight delay registers of four streams cover all 32 inputs.
// - input shift in half master periods, at most 4.5 periods.
// - output advance 15 ns steps to 45 ns, only in codes 000-011.
// - block fill writes pattern bits 13-15 everywhere within two frames.
// - fill clears bits 0-12; go bit self-clears when fill ends.
// - fill starts only with mode bit high and go bit raised.
// - mode bits 11 send the 2^15-1 pseudo-random pattern.
// - selected stream and channel are checked; mismatches are counted.
// - run rise starts counting; run fall copies count to readable register.
// - clear rise zeroes readable count and internal counter.
// - mode bits 00 select variable delay.
// - mode bits 10 select constant delay using alternate frame buffer.
// - data memory write counter advances sequentially, reset by frame pulse.
`timescale 1ns/1ns
module tdm_rate_timing_ctrl
  import tdm_ctrl_pkg::*;
#(
  parameter logic [3:0] MCLK_DIV = 4'h6,
  parameter int CM_DEPTH = 8192
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // host configuration
  input wire tdm_ctrl_pkg::ctrl_cfg_t cfg,
  // serial side
  input wire logic framePulseIn_n,
  input wire logic [31:0] frameEvalInput,
  input wire logic [31:0] serialIn,
  input wire logic txBitTick,
  input wire logic [1:0] channelModeBits,
  // frame alignment status
  output logic [9:0] offsetResult,
  output logic measureDone,
  // per-stream effective delays
  output logic [31:0][3:0] inputDelayEff,
  output logic [31:0][1:0] outputAdvanceEff,
  // data memory timing
  output logic [11:0] dmWriteAddr,
  output logic dmReadBank,
  output logic constantDelay,
  // connection memory fill
  output logic cmWriteEn,
  output logic [12:0] cmWriteAddr,
  output logic [15:0] cmWriteData,
  output logic blockProgGo,
  // pattern and error test
  output logic txUsePrbs,
  output logic txPrbsBit,
  output logic [15:0] errorCount
);
  import tdm_ctrl_pkg::*;

  localparam logic [CM_ADDR_W-1:0] CM_LAST = CM_ADDR_W'(CM_DEPTH - 1);

  ctrl_state_t s_q;
  ctrl_state_t s_d;
  stream_rate_t rateOf [NUM_STREAMS];
  logic [NUM_STREAMS-1:0] activeOf;
  stream_rate_t monRate;
  logic monActive;
  logic prbsBit;

  genvar g;
  generate
    for (g = 0; g < NUM_STREAMS; g++) begin : gRate
      stream_rate_map uMap (
        .rateCode(cfg.rateCode),
        .streamIdx(5'(g)),
        .streamRate(rateOf[g]),
        .streamActive(activeOf[g])
      );
    end
  endgenerate

  stream_rate_map uMonMap (
    .rateCode(cfg.rateCode),
    .streamIdx(cfg.monitorStream),
    .streamRate(monRate),
    .streamActive(monActive)
  );

  prbs_lfsr #(.WIDTH(15)) uGen (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .stepEn(txBitTick),
    .patternBit(prbsBit)
  );

  always_comb begin
    logic frameFall;
    logic evalSel;
    logic evalFall;
    logic [2:0] bitDivLast;
    logic bitTick;
    logic startRise;
    logic goRise;
    logic runRise;
    logic runFall;
    logic clrRise;
    logic rxBit;
    logic expBit;
    logic advAllowed;
    s_d = s_q;
    bitTick = 1'b0;
    frameFall = s_q.fpPrev & ~framePulseIn_n;
    evalSel = frameEvalInput[cfg.evalSelect];
    evalFall = s_q.fePrev & ~evalSel;
    bitDivLast = 3'((4'h8 >> monRate) - 4'h1);
    startRise = cfg.startMeasure & ~s_q.startPrev;
    goRise = cfg.blockProgGoReq & ~s_q.goPrev;
    runRise = cfg.errorTestRun & ~s_q.runPrev;
    runFall = ~cfg.errorTestRun & s_q.runPrev;
    clrRise = cfg.errorCountClear & ~s_q.clrPrev;
    rxBit = serialIn[cfg.monitorStream];
    expBit = s_q.chkShift[14] ^ s_q.chkShift[13];
    advAllowed = (cfg.rateCode <= RATE_16M_8M);
    s_d.fpPrev = framePulseIn_n;
    s_d.fePrev = evalSel;
    s_d.startPrev = cfg.startMeasure;
    s_d.goPrev = cfg.blockProgGoReq;
    s_d.runPrev = cfg.errorTestRun;
    s_d.clrPrev = cfg.errorCountClear;

    // internal master clock enable
    s_d.masterTick = 1'b0;
    if (s_q.mclkDiv >= MCLK_DIV - 4'h1) begin
      s_d.mclkDiv = 4'h0;
      s_d.masterTick = 1'b1;
    end else begin
      s_d.mclkDiv = s_q.mclkDiv + 4'h1;
    end

    // sequential data memory address and frame bank
    if (frameFall) begin
      s_d.dmAddr = 12'h000;
      s_d.byteTick = 3'h0;
      s_d.bank = ~s_q.bank;
    end else if (s_q.masterTick) begin
      s_d.byteTick = s_q.byteTick + 3'h1;
      if (s_q.byteTick == 3'h7) begin
        s_d.dmAddr = s_q.dmAddr + 12'h001;
      end
    end

    // monitored stream bit and channel position
    if (frameFall) begin
      s_d.bitDiv = 3'h0;
      s_d.bitIdx = 3'h0;
      s_d.chanIdx = 8'h00;
    end else if (s_q.masterTick) begin
      if (s_q.bitDiv >= bitDivLast) begin
        s_d.bitDiv = 3'h0;
        bitTick = 1'b1;
        s_d.bitIdx = s_q.bitIdx + 3'h1;
        if (s_q.bitIdx == 3'h7) begin
          s_d.chanIdx = s_q.chanIdx + 8'h01;
        end
      end else begin
        s_d.bitDiv = s_q.bitDiv + 3'h1;
      end
    end

    // frame offset measurement
    if (!cfg.startMeasure) begin
      s_d.measDone = 1'b0;
      if (frameFall) begin
        s_d.lowSeen = 1'b1;
      end
    end
    unique case (s_q.measState)
      MS_IDLE: begin
        if (startRise && s_q.lowSeen) begin
          s_d.measState = MS_MEAS;
          s_d.measFrames = 2'h0;
          s_d.counting = 1'b0;
          s_d.lowSeen = 1'b0;
        end
      end
      MS_MEAS: begin
        if (s_q.counting && s_q.masterTick && s_q.offsetCnt != OFFSET_MAX) begin
          s_d.offsetCnt = s_q.offsetCnt + 10'h001;
        end
        if (s_q.counting && evalFall) begin
          s_d.offsetResult = s_q.offsetCnt;
          s_d.counting = 1'b0;
        end
        if (frameFall) begin
          s_d.measFrames = s_q.measFrames + 2'h1;
          if (s_q.measFrames == 2'h0) begin
            s_d.counting = 1'b1;
            s_d.offsetCnt = 10'h000;
          end
          if (s_q.measFrames + 2'h1 == MEAS_FRAMES) begin
            s_d.measDone = 1'b1;
            s_d.counting = 1'b0;
            s_d.measState = MS_IDLE;
          end
        end
      end
      default: s_d.measState = MS_IDLE;
    endcase

    // per-stream input delay and output advance
    for (int i = 0; i < NUM_STREAMS; i++) begin
      s_d.inDelay[i] = 4'h0;
      if (activeOf[i] && rateOf[i] != SR_2M) begin
        s_d.inDelay[i] = (cfg.inputDelay[i] > IN_DELAY_MAX) ? IN_DELAY_MAX
                         : cfg.inputDelay[i];
      end
      s_d.outAdv[i] = (advAllowed && activeOf[i]) ? cfg.outputAdvance[i] : 2'h0;
    end

    // connection memory block fill
    s_d.cmWe = 1'b0;
    if (s_q.bpGo) begin
      s_d.cmWe = 1'b1;
      s_d.cmData = {cfg.blockPattern, 13'h0000};
      if (s_q.cmWe) begin
        s_d.cmAddr = s_q.cmAddr + 13'h0001;
      end
      if (s_q.cmWe && s_q.cmAddr == CM_LAST) begin
        s_d.cmWe = 1'b0;
        s_d.bpGo = 1'b0;
        s_d.cmAddr = 13'h0000;
      end
    end else if (goRise && cfg.blockProgMode) begin
      s_d.bpGo = 1'b1;
      s_d.cmAddr = 13'h0000;
    end

    // channel mode decode for the current output channel
    s_d.txUsePrbs = (channelModeBits == MODE_PRBS);
    s_d.txPrbs = prbsBit;
    s_d.constDelay = (channelModeBits == MODE_CONSTANT);
    s_d.readBank = (channelModeBits == MODE_CONSTANT) ? ~s_q.bank : s_q.bank;

    // bit error test
    if (runRise) begin
      s_d.seedCnt = 4'h0;
    end
    if (cfg.errorTestRun && bitTick && monActive
        && s_q.chanIdx == cfg.monitorChannel) begin
      s_d.chkShift = {s_q.chkShift[13:0], rxBit};
      if (s_q.seedCnt != PRBS_ORDER) begin
        s_d.seedCnt = s_q.seedCnt + 4'h1;
      end else if (rxBit != expBit && s_q.errInt != ERR_MAX) begin
        s_d.errInt = s_q.errInt + 16'h0001;
      end
    end
    if (runFall) begin
      s_d.errCount = s_q.errInt;
    end
    if (clrRise) begin
      s_d.errCount = 16'h0000;
      s_d.errInt = 16'h0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.fpPrev <= 1'b1;
      s_q.measState <= MS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign offsetResult = s_q.offsetResult;
  assign measureDone = s_q.measDone;
  assign inputDelayEff = s_q.inDelay;
  assign outputAdvanceEff = s_q.outAdv;
  assign dmWriteAddr = s_q.dmAddr;
  assign dmReadBank = s_q.readBank;
  assign constantDelay = s_q.constDelay;
  assign cmWriteEn = s_q.cmWe;
  assign cmWriteAddr = s_q.cmAddr;
  assign cmWriteData = s_q.cmData;
  assign blockProgGo = s_q.bpGo;
  assign txUsePrbs = s_q.txUsePrbs;
  assign txPrbsBit = s_q.txPrbs;
  assign errorCount = s_q.errCount;

endmodule

// ===== verif/tdm_rate_timing_ctrl_monitor.sv
// concurrent checks on the rate and timing control ports
`timescale 1ns/1ns
module tdm_rate_timing_ctrl_monitor
  import tdm_ctrl_pkg::*;
#(
  parameter int CM_DEPTH = 8192
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // inputs
  input wire tdm_ctrl_pkg::ctrl_cfg_t cfg,
  input wire logic framePulseIn_n,
  input wire logic [1:0] channelModeBits,
  // outputs
  input wire logic measureDone,
  input wire logic [31:0][3:0] inputDelayEff,
  input wire logic [31:0][1:0] outputAdvanceEff,
  input wire logic [11:0] dmWriteAddr,
  input wire logic constantDelay,
  input wire logic cmWriteEn,
  input wire logic [12:0] cmWriteAddr,
  input wire logic [15:0] cmWriteData,
  input wire logic blockProgGo,
  input wire logic txUsePrbs,
  input wire logic [15:0] errorCount
);
  import tdm_ctrl_pkg::*;
  logic [3:0] fpLow_q;
  always_ff @(posedge core_clk) begin
    fpLow_q <= {fpLow_q[2:0], !framePulseIn_n};
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence goReq;
    $rose(cfg.blockProgGoReq) && cfg.blockProgMode && !blockProgGo;
  endsequence
  sequence fillStart;
    blockProgGo ##1 (cmWriteEn && cmWriteAddr == 13'h0);
  endsequence
  go_start_a: assert property (goReq |=> fillStart)
    else $error("fill did not start after go request");
  go_refuse_a: assert property ($rose(cfg.blockProgGoReq) && !cfg.blockProgMode
    && !blockProgGo |=> !blockProgGo)
    else $error("fill started with mode bit low");
  fill_step_a: assert property (cmWriteEn && $past(cmWriteEn)
    |-> cmWriteAddr == $past(cmWriteAddr) + 13'h1)
    else $error("fill address not sequential");
  fill_data_a: assert property (cmWriteEn
    |-> cmWriteData == {$past(cfg.blockPattern), 13'h0})
    else $error("fill data wrong");
  fill_end_a: assert property ($fell(cmWriteEn)
    |-> !blockProgGo && $past(cmWriteAddr) == 13'(CM_DEPTH - 1))
    else $error("fill ended wrongly");
  done_rise_a: assert property ($rose(measureDone)
    |-> $past(framePulseIn_n, 1) == 1'b0 && $past(framePulseIn_n, 2))
    else $error("done flag not tied to frame fall");
  done_clear_a: assert property (measureDone && !cfg.startMeasure |=> !measureDone)
    else $error("done flag did not clear");
  err_clear_a: assert property ($rose(cfg.errorCountClear) |=> errorCount == 16'h0)
    else $error("error count not cleared");
  err_hold_a: assert property (!$rose(cfg.errorCountClear) && !$fell(cfg.errorTestRun)
    |=> $stable(errorCount))
    else $error("error count changed without cause");
  adv_rate_a: assert property (cfg.rateCode > RATE_16M_8M |=> outputAdvanceEff == '0)
    else $error("output advance in slow rate");
  delay_slow_a: assert property (cfg.rateCode == RATE_2M |=> inputDelayEff == '0)
    else $error("input delay on slow stream");
  mode_dec_a: assert property (channelModeBits == MODE_PRBS |=> txUsePrbs && !constantDelay)
    else $error("pattern mode not decoded");
  dm_reset_a: assert property (dmWriteAddr < $past(dmWriteAddr) |-> |fpLow_q)
    else $error("write address dropped off frame");
endmodule

// ===== verif/tdm_frame_source.sv
// far side model: frame pulse, evaluation inputs and serial data
`timescale 1ns/1ns
module tdm_frame_source #(
  parameter int FRAME = 480
)
(
  // clock
  input wire logic core_clk,
  // data control
  input wire logic [4:0] onesStream,
  input wire logic onesOn,
  // serial side
  output logic framePulseIn_n,
  output logic [31:0] frameEvalInput,
  output logic [31:0] serialIn,
  output logic txBitTick
);
  int ph = 0;
  always @(negedge core_clk) begin
    ph <= (ph + 1) % FRAME;
  end
  always_comb begin
    framePulseIn_n = (ph != 0);
    txBitTick = (ph % 6 == 0);
    serialIn = onesOn ? 32'h0000_0001 << onesStream : 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      frameEvalInput[i] = !(ph >= 18 + 12 * i && ph < 26 + 12 * i);
    end
  end
endmodule

// ===== verif/tdm_rate_timing_ctrl_tb.sv
// self-checking testbench for the rate and timing control
`timescale 1ns/1ns
module tdm_rate_timing_ctrl_tb;
  import tdm_ctrl_pkg::*;
  localparam int DEPTH = 16;
  logic core_clk;
  logic sys_rst = 1'b1;
  ctrl_cfg_t cfg = '0;
  logic [1:0] channelModeBits = 2'h0;
  logic [4:0] onesStream = 5'h00;
  logic onesOn = 1'b0;
  logic framePulseIn_n;
  logic [31:0] frameEvalInput;
  logic [31:0] serialIn;
  logic txBitTick;
  logic [9:0] offsetResult;
  logic measureDone;
  logic [31:0][3:0] inputDelayEff;
  logic [31:0][1:0] outputAdvanceEff;
  logic [11:0] dmWriteAddr;
  logic dmReadBank;
  logic constantDelay;
  logic cmWriteEn;
  logic [12:0] cmWriteAddr;
  logic [15:0] cmWriteData;
  logic blockProgGo;
  logic txUsePrbs;
  logic txPrbsBit;
  logic [15:0] errorCount;
  int n_fail = 0;
  int n_tests = 0;
  logic [28:0] expQ[$];
  logic [14:0] refShift = PRBS_SEED;
  logic refBit = 1'b0;
  logic bankSeen;
  tdm_rate_timing_ctrl #(.CM_DEPTH(DEPTH)) dut (
    .core_clk, .sys_rst, .cfg, .framePulseIn_n, .frameEvalInput, .serialIn, .txBitTick,
    .channelModeBits, .offsetResult, .measureDone, .inputDelayEff, .outputAdvanceEff,
    .dmWriteAddr, .dmReadBank, .constantDelay, .cmWriteEn, .cmWriteAddr, .cmWriteData,
    .blockProgGo, .txUsePrbs, .txPrbsBit, .errorCount);
  tdm_frame_source src (
    .core_clk, .onesStream, .onesOn, .framePulseIn_n, .frameEvalInput, .serialIn,
    .txBitTick);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [28:0] e, input logic [28:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chkIn(input int lo, input int hi, input logic [15:0] g);
    n_tests++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h..%h got=%h", $time, lo, hi, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic bit act(input int c, input int s);
    return c == 1 ? s < 16 : c == 3 ? s < 20 : c != 7;
  endfunction
  task automatic meas(input int sel);
    int n;
    n = 0;
    cfg.evalSelect = 5'(sel);
    cfg.startMeasure = 1'b0;
    cyc(500);
    cfg.startMeasure = 1'b1;
    while (!measureDone && n < 1500) begin
      cyc(1);
      n++;
    end
    chkIn(481, 962, 16'(n));
    chkIn(2 + 2 * sel, 4 + 2 * sel, 16'(offsetResult));
    cfg.startMeasure = 1'b0;
    cyc(2);
    chk(29'h0, 29'(measureDone));
  endtask
  task automatic fill(input logic mode, input logic [2:0] pat);
    cfg.blockProgMode = mode;
    cfg.blockPattern = pat;
    for (int k = 0; k < DEPTH; k++) begin
      if (mode) expQ.push_back({13'(k), pat, 13'h0});
    end
    cfg.blockProgGoReq = 1'b1;
    cyc(4);
    cfg.blockProgGoReq = 1'b0;
    cyc(1);
    cfg.blockProgGoReq = 1'b1;
    cyc(DEPTH + 4);
    chk(29'h0, 29'({blockProgGo, 1'(expQ.size() != 0)}));
    cfg.blockProgGoReq = 1'b0;
    cyc(1);
  endtask
  task automatic ber(input logic [4:0] strm);
    onesStream = strm;
    onesOn = 1'b1;
    cfg.errorTestRun = 1'b1;
    cyc(3000);
    cfg.errorTestRun = 1'b0;
    cyc(2);
  endtask
  always @(posedge core_clk) begin
    refShift <= sys_rst ? PRBS_SEED
      : txBitTick ? {refShift[13:0], refShift[14] ^ refShift[13]} : refShift;
    refBit <= !sys_rst && refShift[14];
  end
  always @(negedge core_clk) begin
    chk(29'(refBit), 29'(txPrbsBit));
    if (cmWriteEn === 1'b1) begin
      chk(expQ.size() > 0 ? expQ.pop_front() : '1, {cmWriteAddr, cmWriteData});
    end
  end
  initial begin
    void'($urandom(5973));
    cyc(4);
    sys_rst = 1'b0;
    cyc(1);
    chk(29'h0, 29'({measureDone, blockProgGo, cmWriteEn, errorCount}));
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      cfg.rateCode = rate_code_t'(c);
      for (int s = 0; s < 32; s++) begin
        cfg.inputDelay[s] = 4'($urandom_range(15));
        cfg.outputAdvance[s] = 2'($urandom);
      end
      cyc(2);
      for (int s = 0; s < 32; s++) begin
        chk(29'({(act(c, s) && c != 6 && !(c == 5 && s < 16)) ?
          (cfg.inputDelay[s] > 9 ? 4'h9 : cfg.inputDelay[s]) : 4'h0,
          (act(c, s) && c < 4) ? cfg.outputAdvance[s] : 2'h0}),
          29'({inputDelayEff[s], outputAdvanceEff[s]}));
      end
    end
    $display("test rates done");
    for (int m = 0; m < 4; m++) begin
      channelModeBits = 2'(m);
      cyc(2);
      chk(29'({m == 2, m == 3}), 29'({constantDelay, txUsePrbs}));
    end
    while (framePulseIn_n) cyc(1);
    channelModeBits = MODE_VARIABLE;
    cyc(2);
    bankSeen = dmReadBank;
    channelModeBits = MODE_CONSTANT;
    cyc(2);
    chk(29'(!bankSeen), 29'(dmReadBank));
    $display("test modes done");
    meas(0);
    meas(31);
    meas($urandom_range(30));
    $display("test measure done");
    fill(1'b0, 3'h7);
    fill(1'b1, 3'($urandom));
    fill(1'b1, 3'h5);
    $display("test fill done");
    cfg.rateCode = RATE_16M;
    cfg.monitorStream = 5'h05;
    cfg.monitorChannel = 8'($urandom_range(8));
    ber(5'h05);
    chkIn(1, 65535, errorCount);
    cfg.errorCountClear = 1'b1;
    cyc(2);
    chk(29'h0, 29'(errorCount));
    cfg.errorCountClear = 1'b0;
    ber(5'h04);
    chk(29'h0, 29'(errorCount));
    $display("test error done");
    summarize();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    summarize();
  end
endmodule
bind tdm_rate_timing_ctrl tdm_rate_timing_ctrl_monitor #(.CM_DEPTH(CM_DEPTH)) mon (
  .core_clk, .sys_rst, .cfg, .framePulseIn_n, .channelModeBits, .measureDone,
  .inputDelayEff, .outputAdvanceEff, .dmWriteAddr, .constantDelay, .cmWriteEn,
  .cmWriteAddr, .cmWriteData, .blockProgGo, .txUsePrbs, .errorCount);
